// file: verilog/sar_regs.svh
// Timing, width and layout constants of the converter readout block.
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH

`define SAR_CLK_PERIOD_NS 50
`define SAR_CONV_TIME_NS 3000
`define SAR_WORD_BITS 16
`define SAR_NUM_CH 6
`define SAR_RES_BITS 16
`define SAR_FIFO_DEPTH 32
`define SAR_LANE_BITS 96
`define SAR_OWN_BITS_ONE 8'h60
`define SAR_OWN_BITS_TWO 8'h30
`define SAR_OWN_BITS_THREE 8'h20
`define SAR_INS_IDX_ONE 7'h00
`define SAR_INS_IDX_TWO 7'h30
`define SAR_INS_IDX_THREE 7'h40
`define SAR_MASK_ONE 3'h1
`define SAR_MASK_TWO 3'h3
`define SAR_MASK_THREE 3'h7

`endif

// file: verilog/sar_pkg.sv
// Types shared by the converter readout block.
`default_nettype none
`include "sar_regs.svh"
package sar_pkg;

	typedef enum logic [1:0] {
		SAR_ST_IDLE = 2'b01,
		SAR_ST_CONV = 2'b10
	} sar_conv_state_t;

	typedef enum logic [2:0] {
		SAR_LANES_ONE = 3'b001,
		SAR_LANES_TWO = 3'b010,
		SAR_LANES_THREE = 3'b100
	} sar_lane_mode_t;

	typedef logic [`SAR_NUM_CH-1:0][`SAR_WORD_BITS-1:0] sar_words_t;

endpackage : sar_pkg
`default_nettype wire

// file: verilog/sar_sync.sv
// Two-flop synchroniser for a vector of asynchronous pin levels.
`default_nettype none
module sar_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : sar_sync
`default_nettype wire

// file: verilog/sar_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides.
`default_nettype none
module sar_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic push;
	logic pop;

	assign in_ready = (wr_ptr_r - rd_ptr_r) != (AW + 1)'(DEPTH);
	assign out_valid = wr_ptr_r != rd_ptr_r;
	assign out_data = mem[rd_ptr_r[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule : sar_fifo
`default_nettype wire

// file: verilog/sar_readout_top.sv
// Conversion control and serial readout of a six-channel converter.
`default_nettype none
`include "sar_regs.svh"
module sar_readout_top
	import sar_pkg::*;
#(
	parameter int RES_BITS = `SAR_RES_BITS,
	parameter int FIFO_DEPTH = `SAR_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [2:0] pair_conversion_trigger,
	input wire logic soft_select_mode,
	input wire logic span_select,
	input wire logic [2:0] pair_select_bits,
	input wire logic [2:0] pair_span_bit,
	input wire logic [`SAR_NUM_CH*RES_BITS-1:0] conv_data,
	input wire logic serial_parallel_select,
	input wire logic lane_a_enable,
	input wire logic lane_b_enable,
	input wire logic lane_c_enable,
	input wire logic chain_enable,
	input wire logic [2:0] chain_input_lanes,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic low_power_request_n,
	output logic busy,
	output logic [2:0] conv_span,
	output logic [2:0] pair_power_down,
	output logic standby,
	output logic [2:0] dout,
	output logic [2:0] dout_oe
);
	localparam int CONV_CYCLES = `SAR_CONV_TIME_NS / `SAR_CLK_PERIOD_NS;
	localparam int CNT_W = $clog2(CONV_CYCLES + 1);
	localparam int LB = `SAR_LANE_BITS;
	localparam int WB = `SAR_WORD_BITS;

	logic [2:0] trig_s, sel_s, rng_s, lane_en_s, cin_s;
	logic sw_mode_s, span_s, ser_s, chain_enable_s, cs_n_s, sclk_s, lp_n_s;

	sar_sync #(.WIDTH(22)) u_sync (
		.clk(clk),
		.reset(reset),
		.d({pair_conversion_trigger, pair_select_bits, pair_span_bit,
			lane_c_enable, lane_b_enable, lane_a_enable, chain_input_lanes,
			soft_select_mode, span_select, serial_parallel_select,
			chain_enable, cs_n, sclk, low_power_request_n}),
		.q({trig_s, sel_s, rng_s, lane_en_s, cin_s, sw_mode_s, span_s,
			ser_s, chain_enable_s, cs_n_s, sclk_s, lp_n_s})
	);

	// Trigger history resets high, but the synchroniser resets low, so a tied-high trigger still shows one rising edge after reset.
	// Chip select and clock history match the synchroniser's reset level,
	// so no false falling edge is seen while the idle-high pins arrive.
	logic [2:0] trig_q_r;
	logic cs_n_q_r, sclk_q_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			trig_q_r <= 3'h7;
			cs_n_q_r <= 1'b0;
			sclk_q_r <= 1'b0;
		end else begin
			trig_q_r <= trig_s;
			cs_n_q_r <= cs_n_s;
			sclk_q_r <= sclk_s;
		end
	end

	logic [2:0] trig_rise;
	logic cs_fall, cs_rise, sclk_rise, sclk_fall;
	assign trig_rise = trig_s & ~trig_q_r;
	assign cs_fall = cs_n_q_r && !cs_n_s;
	assign cs_rise = !cs_n_q_r && cs_n_s;
	assign sclk_rise = !sclk_q_r && sclk_s;
	assign sclk_fall = sclk_q_r && !sclk_s;

	sar_conv_state_t state_r;
	logic [CNT_W-1:0] cnt_r;
	logic busy_r, standby_r;
	logic [2:0] conv_pairs_r, conv_span_r, hw_span_r, pd_r, pair_req;
	logic busy_fall, conv_start;

	// A powered-down pair's first rising edge only wakes it up.
	assign pair_req = sw_mode_s ? (trig_rise[0] ? sel_s : 3'h0)
		: (trig_rise & ~pd_r);
	assign conv_start = (state_r == SAR_ST_IDLE) && !standby_r
		&& (pair_req != 3'h0);
	assign busy_fall = (state_r == SAR_ST_CONV)
		&& (cnt_r == CNT_W'(CONV_CYCLES - 1));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= SAR_ST_IDLE;
			cnt_r <= '0;
			busy_r <= 1'b0;
			conv_pairs_r <= 3'h0;
			conv_span_r <= 3'h0;
		end else begin
			case (state_r)
				SAR_ST_IDLE: begin
					if (conv_start) begin
						state_r <= SAR_ST_CONV;
						cnt_r <= '0;
						busy_r <= 1'b1;
						conv_pairs_r <= pair_req;
						conv_span_r <= sw_mode_s ? rng_s : hw_span_r;
					end
				end
				SAR_ST_CONV: begin
					cnt_r <= cnt_r + 1'b1;
					if (busy_fall) begin
						state_r <= SAR_ST_IDLE;
						busy_r <= 1'b0;
					end
				end
				default: begin
					state_r <= SAR_ST_IDLE;
					busy_r <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hw_span_r <= 3'h0;
		end else if (busy_fall && !sw_mode_s) begin
			hw_span_r <= {3{span_s}};
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pd_r <= 3'h0;
		end else if (sw_mode_s) begin
			pd_r <= 3'h0;
		end else begin
			pd_r <= (pd_r & ~trig_rise)
				| (busy_fall ? ~trig_s : 3'h0);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			standby_r <= 1'b0;
		end else begin
			standby_r <= !lp_n_s;
		end
	end

	// Results are staged through the FIFO so that a read frame in progress
	// is never disturbed; the output words update only between frames.
	sar_words_t cap_r, res_r;
	logic [2:0] wr_idx_r;
	logic push_pend_r, wr_sel, fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [WB+2:0] fifo_out_data;
	logic in_frame_r, fresh_r, load;
	assign wr_sel = conv_pairs_r[wr_idx_r[2:1]];

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cap_r <= '0;
			push_pend_r <= 1'b0;
			wr_idx_r <= 3'h0;
		end else if (busy_fall) begin
			for (int k = 0; k < `SAR_NUM_CH; k++) begin
				cap_r[k] <= WB'(conv_data[k*RES_BITS +: RES_BITS]);
			end
			push_pend_r <= 1'b1;
			wr_idx_r <= 3'h0;
		end else if (push_pend_r && (fifo_in_ready || !wr_sel)) begin
			if (wr_idx_r == 3'h5) begin
				push_pend_r <= 1'b0;
			end
			wr_idx_r <= wr_idx_r + 3'h1;
		end
	end

	sar_fifo #(.WIDTH(WB + 3), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.reset(reset),
		.in_valid(push_pend_r && wr_sel),
		.in_ready(fifo_in_ready),
		.in_data({wr_idx_r, cap_r[wr_idx_r]}),
		.out_valid(fifo_out_valid),
		.out_ready(!in_frame_r),
		.out_data(fifo_out_data)
	);
	assign fifo_pop = fifo_out_valid && !in_frame_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			res_r <= '0;
			fresh_r <= 1'b0;
		end else begin
			if (fifo_pop) begin
				res_r[fifo_out_data[WB+2:WB]] <= fifo_out_data[WB-1:0];
			end
			fresh_r <= fifo_pop || (fresh_r && !load);
		end
	end

	sar_lane_mode_t mode;
	logic [2:0] lane_mask;
	logic [7:0] own_bits, total_bits, bit_cnt_r;
	logic [6:0] ins_idx;
	always_comb begin
		if (lane_en_s == 3'h7) begin
			mode = SAR_LANES_THREE;
			lane_mask = `SAR_MASK_THREE;
			own_bits = `SAR_OWN_BITS_THREE;
			ins_idx = `SAR_INS_IDX_THREE;
		end else if (lane_en_s[1:0] == 2'h3) begin
			mode = SAR_LANES_TWO;
			lane_mask = `SAR_MASK_TWO;
			own_bits = `SAR_OWN_BITS_TWO;
			ins_idx = `SAR_INS_IDX_TWO;
		end else begin
			mode = SAR_LANES_ONE;
			lane_mask = `SAR_MASK_ONE & lane_en_s;
			own_bits = `SAR_OWN_BITS_ONE;
			ins_idx = `SAR_INS_IDX_ONE;
		end
		total_bits = chain_enable_s ? 8'(own_bits << 1) : own_bits;
	end

	function automatic logic [LB-1:0] lane_image(input int lane,
		input sar_lane_mode_t m, input sar_words_t w);
		logic [LB-1:0] img;
		img = '0;
		case (m)
			SAR_LANES_THREE: begin
				img = {w[2*lane], w[2*lane+1], 64'h0};
			end
			SAR_LANES_TWO: begin
				if (lane == 0) begin
					img = {w[0], w[1], w[4], 48'h0};
				end else if (lane == 1) begin
					img = {w[2], w[3], w[5], 48'h0};
				end
			end
			default: begin
				if (lane == 0) begin
					img = {w[0], w[1], w[2], w[3], w[4], w[5]};
				end
			end
		endcase
		return img;
	endfunction : lane_image

	// A new frame reloads only when fresh results wait or the previous
	// readout is exhausted, so split 16-clock frames read successive words.
	logic seen_fall_r, shift_en;
	assign load = cs_fall && ser_s && (fresh_r || bit_cnt_r >= total_bits);
	assign shift_en = sclk_rise && in_frame_r && seen_fall_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			in_frame_r <= 1'b0;
			seen_fall_r <= 1'b0;
			bit_cnt_r <= 8'h00;
		end else begin
			if (cs_fall && ser_s) begin
				in_frame_r <= 1'b1;
				seen_fall_r <= 1'b0;
			end else if (cs_rise) begin
				in_frame_r <= 1'b0;
			end else if (sclk_fall && in_frame_r) begin
				seen_fall_r <= 1'b1;
			end
			if (load) begin
				bit_cnt_r <= 8'h00;
			end else if (shift_en && bit_cnt_r != 8'hff) begin
				bit_cnt_r <= bit_cnt_r + 8'h01;
			end
		end
	end

	logic [2:0] oe_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			oe_r <= 3'h0;
		end else if (cs_fall && ser_s) begin
			oe_r <= lane_mask;
		end else if (cs_rise || !ser_s) begin
			oe_r <= 3'h0;
		end
	end
	assign dout_oe = oe_r;

	for (genvar g = 0; g < 3; g++) begin : g_lane
		logic [LB-1:0] sh_r, img, shifted;
		logic dout_r, cin_cap_r;
		assign img = lane_image(g, mode, res_r);
		always_comb begin
			shifted = {sh_r[LB-2:0], 1'b0};
			shifted[ins_idx] = cin_cap_r;
		end
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				sh_r <= '0;
				dout_r <= 1'b0;
				cin_cap_r <= 1'b0;
			end else begin
				if (load) begin
					sh_r <= img;
					dout_r <= img[LB-1];
				end else if (shift_en) begin
					sh_r <= shifted;
					dout_r <= sh_r[LB-2];
				end
				if (sclk_fall && in_frame_r) begin
					cin_cap_r <= chain_enable_s && cin_s[g];
				end
			end
		end
		assign dout[g] = dout_r;
	end

	assign busy = busy_r;
	assign conv_span = conv_span_r;
	assign pair_power_down = pd_r;
	assign standby = standby_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	busy_length_a: assert property ($fell(busy_r) |->
		$past(cnt_r) == CNT_W'(CONV_CYCLES - 1))
		else $error("busy did not last the conversion time");
	busy_start_a: assert property (conv_start |=> busy_r && conv_pairs_r != 0)
		else $error("trigger edge did not raise busy");
	hw_span_a: assert property (busy_fall && !sw_mode_s |=>
		hw_span_r == {3{$past(span_s)}})
		else $error("span pin not latched at busy fall");
	span_hold_a: assert property (!busy_fall |=> $stable(hw_span_r))
		else $error("span changed away from busy fall");
	sw_span_a: assert property (conv_start && sw_mode_s |=>
		conv_span_r == $past(rng_s))
		else $error("software span bits not applied");
	sw_trig_a: assert property (sw_mode_s && !trig_rise[0] |-> !conv_start)
		else $error("software mode started without trigger A");
	result_load_a: assert property ($fell(busy_r) && conv_pairs_r[0]
		&& !in_frame_r && !cs_fall |-> ##[1:12] fresh_r)
		else $error("results not loaded after conversion");
	frame_oe_a: assert property (load |=>
		dout_oe == $past(lane_mask) && dout[0] == $past(g_lane[0].img[LB-1]))
		else $error("frame start did not present MSB");
	float_a: assert property (cs_rise |=> dout_oe == 3'h0)
		else $error("lanes still driven after chip select rose");
	shift_bit_a: assert property (shift_en && !load |=>
		dout[1] == $past(g_lane[1].sh_r[LB-2]))
		else $error("lane did not shift on rising clock");
	chain_cap_a: assert property (sclk_fall && in_frame_r |=>
		g_lane[0].cin_cap_r == $past(chain_enable_s && cin_s[0]))
		else $error("chain input not captured");
	power_down_a: assert property (busy_fall && !sw_mode_s && !trig_s[1]
		|=> pd_r[1])
		else $error("pair did not power down");
	standby_a: assert property (!lp_n_s |=> standby_r && !conv_start)
		else $error("standby not entered");

	conv_done_c: cover property ($rose(busy_r) ##[60:70] fresh_r);
	chain_frame_c: cover property (chain_enable_s && load ##[1:900]
		bit_cnt_r == 8'h60);
	two_lane_c: cover property (mode == SAR_LANES_TWO && load);
	wake_c: cover property (pd_r[2] ##[1:200] !pd_r[2]);
endmodule : sar_readout_top
`default_nettype wire

// file: test/sar_host_model.sv
// Host-side serial reader model for the converter readout block.
`default_nettype none
module sar_host_model (
	input wire logic clk,
	input wire logic [2:0] dout,
	input wire logic [2:0] dout_oe,
	output var logic cs_n,
	output var logic sclk
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [95:0] cap_a, cap_b, cap_c;
	logic [2:0] oe_seen;
	// The parallel read strobe has no port here and is taken as held low.
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	// The clock stands high outside frames; bits are taken on its fall.
	// A long high phase leaves the synchronised lane time to settle.
	task automatic read_frame(input int n);
		cs_n = 1'b0;
		step(8);
		oe_seen = dout_oe;
		for (int i = 0; i < n; i++) begin
			sclk = 1'b0;
			cap_a = {cap_a[94:0], dout[0]};
			cap_b = {cap_b[94:0], dout[1]};
			cap_c = {cap_c[94:0], dout[2]};
			step(2);
			sclk = 1'b1;
			step(6);
		end
		cs_n = 1'b1;
		step(8);
	endtask : read_frame
endmodule : sar_host_model
`default_nettype wire

// file: test/sar_readout_top_test.sv
// Self-checking bench for the converter readout block.
`default_nettype none
`include "sar_regs.svh"
module sar_readout_top_test
	import sar_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RB = 14;
	localparam int CONV = `SAR_CONV_TIME_NS / `SAR_CLK_PERIOD_NS;
	logic clk, reset, soft_select_mode, span_select, chain_enable;
	logic low_power_request_n, busy, standby, cs_n, sclk;
	logic [2:0] trig, pair_select_bits, pair_span_bit, ln, chain_input_lanes;
	logic [2:0] conv_span, pair_power_down, dout, dout_oe;
	logic [6*RB-1:0] conv_data;
	logic [31:0] seed = 32'h0000_60c1;
	logic [31:0] tmp;
	int mismatches = 0;
	int samples_checked = 0;

	sar_readout_top #(.RES_BITS(RB), .FIFO_DEPTH(32)) i_sar_readout_top (
		.clk(clk), .reset(reset), .pair_conversion_trigger(trig),
		.soft_select_mode(soft_select_mode), .span_select(span_select),
		.pair_select_bits(pair_select_bits), .pair_span_bit(pair_span_bit),
		.conv_data(conv_data), .serial_parallel_select(1'b1),
		.lane_a_enable(ln[0]), .lane_b_enable(ln[1]), .lane_c_enable(ln[2]),
		.chain_enable(chain_enable), .chain_input_lanes(chain_input_lanes),
		.cs_n(cs_n), .sclk(sclk), .low_power_request_n(low_power_request_n),
		.busy(busy), .conv_span(conv_span), .pair_power_down(pair_power_down),
		.standby(standby), .dout(dout), .dout_oe(dout_oe));
	sar_host_model i_sar_host_model (.clk(clk), .dout(dout),
		.dout_oe(dout_oe), .cs_n(cs_n), .sclk(sclk));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [15:0] wd(input int k);
		return 16'(conv_data[k*RB+:RB]);
	endfunction : wd
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic check(input string nm, input logic [95:0] e,
		input logic [95:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic end_test(input string nm);
		$display("end of test %s", nm);
	endtask : end_test
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	// Triggers are only raised while busy is low.
	task automatic convert(input logic [2:0] m, input logic [2:0] es);
		int n;
		for (int k = 0; k < 6; k++) begin
			tmp = rnd();
			conv_data[k*RB+:RB] = tmp[RB-1:0];
		end
		trig = 3'b000;
		step(6);
		trig = m;
		n = 0;
		while (busy !== 1'b1 && n < 20) begin
			step(1);
			n++;
		end
		check("busy_rise", 1, busy);
		check("conv_span", es, conv_span);
		n = 0;
		while (busy === 1'b1 && n < 200) begin
			step(1);
			n++;
		end
		check("busy_len", CONV, n);
		step(20);
	endtask : convert
	task automatic idle_check(input logic [2:0] m);
		trig = 3'b000;
		step(6);
		trig = m;
		step(20);
		check("busy_idle", 0, busy);
	endtask : idle_check
	task automatic frame_check(input int n, input logic [95:0] ea,
		input logic [95:0] eb, input logic [95:0] ec, input logic [2:0] eo);
		logic [95:0] mk;
		mk = (96'h1 << n) - 1;
		i_sar_host_model.read_frame(n);
		check("lane_a", ea, i_sar_host_model.cap_a & mk);
		check("lane_b", eb, i_sar_host_model.cap_b & mk);
		check("lane_c", ec, i_sar_host_model.cap_c & mk);
		check("oe_frame", eo, i_sar_host_model.oe_seen);
		check("oe_idle", 0, dout_oe);
	endtask : frame_check

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#3_000_000;
		mismatches++;
		tally_and_finish();
	end
	initial begin
		reset = 1'b1;
		trig = 3'b000;
		soft_select_mode = 1'b0;
		span_select = 1'b1;
		pair_select_bits = 3'b000;
		pair_span_bit = 3'b000;
		conv_data = '0;
		ln = 3'b111;
		chain_enable = 1'b0;
		chain_input_lanes = 3'b000;
		low_power_request_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		reset = 1'b0;
		step(4);
		convert(3'b111, 3'b000);
		span_select = 1'b0;
		convert(3'b111, 3'b111);
		convert(3'b111, 3'b000);
		end_test("span");
		frame_check(32, {wd(0), wd(1)}, {wd(2), wd(3)}, {wd(4), wd(5)}, 3'b111);
		frame_check(16, wd(0), wd(2), wd(4), 3'b111);
		frame_check(16, wd(1), wd(3), wd(5), 3'b111);
		ln = 3'b011;
		convert(3'b111, 3'b000);
		frame_check(48, {wd(0), wd(1), wd(4)}, {wd(2), wd(3), wd(5)}, 0, ln);
		ln = 3'b001;
		convert(3'b111, 3'b000);
		for (int k = 0; k < 6; k++) begin
			frame_check(16, wd(k), 0, 0, ln);
		end
		end_test("lanes");
		ln = 3'b011;
		chain_enable = 1'b1;
		chain_input_lanes = 3'b001;
		frame_check(96, {wd(0), wd(1), wd(4), 48'hffff_ffff_ffff},
			{wd(2), wd(3), wd(5), 48'h0000}, 0, ln);
		ln = 3'b111;
		chain_input_lanes = 3'b010;
		frame_check(64, {wd(0), wd(1), 32'h0000}, {wd(2), wd(3), 32'hffff_ffff},
			{wd(4), wd(5), 32'h0000}, ln);
		chain_enable = 1'b0;
		end_test("chain");
		convert(3'b011, 3'b000);
		check("pdown", 3'b100, pair_power_down);
		trig = 3'b111;
		step(6);
		check("pwake", 3'b000, pair_power_down);
		check("wake_busy", 0, busy);
		step(20);
		convert(3'b111, 3'b000);
		end_test("power_down");
		low_power_request_n = 1'b0;
		step(6);
		check("standby", 1, standby);
		idle_check(3'b111);
		frame_check(32, {wd(0), wd(1)}, {wd(2), wd(3)}, {wd(4), wd(5)}, ln);
		low_power_request_n = 1'b1;
		step(20);
		check("wake", 0, standby);
		end_test("standby");
		soft_select_mode = 1'b1;
		pair_select_bits = 3'b111;
		tmp = rnd();
		pair_span_bit = tmp[2:0];
		idle_check(3'b010);
		convert(3'b001, pair_span_bit);
		end_test("software");
		tally_and_finish();
	end
endmodule : sar_readout_top_test
`default_nettype wire
